/* File: verilog/mode_exchange.sv */
// Job/monitor exchange: faults, external flags, package moves
`default_nettype none
// How it works
// - Any access or external interrupt in job mode forces monitor mode.
// - In monitor mode interrupts are recognised only during the idle op.
// - External flags stay pending through job mode until an explicit clear.
// - Job reference to a page with no translation raises access fault.
// - Job reference forbidden by the key's permission code faults.
// - Any job reference may fault, even mid vector or string op.
// - Word E holds zeros, cause nibble and faulting virtual address.
// - Cause bits: missing entry, write, read, fetch violation.
// - One cause bit only, except a write to a missing page.
// - Access faults enter monitor at address in register 7.
// - An arriving external line sets its flag bit.
// - Line 0, 13 and 14 unused; 1..12 channels; 15 the timer.
// - Timer reaching zero signals line 15, setting flag 15.
// - Package is 16 words at an address with low 10 bits zero.
// - Entering job mode loads the package into the CPU registers.
// - Leaving job mode stores the CPU registers as the package.
// - Saved word 0 is the resume address, or the illegal op's.
// - Each key has a 4-bit code blocking write, read or fetch.
// - Word 3 keeps flags, interrupt flag, load/store and subfunction.
// - Package keeps fault-test, counter enable and code-set select.
// - Word C low half holds string state of the interrupted op.
// - Monitor entry uses register 3, 5, 6 or 7 by cause.
// - Package is saved at the address it was loaded from.
module mode_exchange
  import xchg_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic [15:0] EXT_LINE,
  input  wire logic        REF_VALID,
  input  wire ref_t        REF_KIND,
  input  wire logic        REF_HIT,
  input  wire logic [1:0]  REF_KEY,
  input  wire logic [47:0] REF_VADDR,
  input  wire logic        EXIT_FORCE,
  input  wire logic        ILLEGAL_OP,
  input  wire logic [47:0] RESUME_PC,
  input  wire logic [11:0] CPU_FLAGS,
  input  wire logic [2:0]  CPU_MODES,
  input  wire logic [63:0] CPU_WORD,
  output logic      [3:0]  SAVE_IDX,
  output logic             LOAD_VALID,
  output logic      [3:0]  LOAD_IDX,
  output logic      [63:0] LOAD_DATA,
  output logic             JOB_MODE,
  output logic      [2:0]  MON_REG_SEL,
  input  wire logic [63:0] MON_REG_DATA,
  output logic             MON_START,
  output logic      [47:0] MON_PC,
  output logic             IDLE_WAKE,
  output logic             MEM_REQ,
  output logic             MEM_WE,
  output logic      [31:0] MEM_ADDR,
  output logic      [63:0] MEM_WDATA,
  input  wire logic [63:0] MEM_RDATA,
  input  wire logic        MEM_ACK
);

  xstate_t     state;
  xstate_t     next_state;
  logic [3:0]  idx;
  logic [3:0]  next_idx;
  logic [31:0] base;
  logic [31:0] next_base;
  logic [31:0] job_base;
  logic [31:0] next_job_base;
  logic [15:0] ext_flag;
  logic [15:0] next_ext_flag;
  logic [15:0] ext_s1;
  logic [15:0] ext_s2;
  logic [15:0] ext_q;
  logic        idle;
  logic        next_idle;
  logic        wake;
  logic        next_wake;
  logic [63:0] fault_word;
  logic [63:0] next_fault_word;
  logic        fault_hold;
  logic        next_fault_hold;
  logic [63:0] key_word;
  logic [63:0] next_key_word;
  logic [2:0]  vec;
  logic [2:0]  next_vec;
  logic        mem_req;
  logic        next_mem_req;
  logic        mem_we;
  logic        next_mem_we;
  logic [31:0] mem_addr;
  logic [31:0] next_mem_addr;
  logic [63:0] mem_wdata;
  logic [63:0] next_mem_wdata;
  logic        load_valid;
  logic        next_load_valid;
  logic [3:0]  load_idx;
  logic [3:0]  next_load_idx;
  logic [63:0] load_data;
  logic [63:0] next_load_data;
  logic        mon_start;
  logic        next_mon_start;
  logic [47:0] mon_pc;
  logic [47:0] next_mon_pc;
  logic [31:0] prdata;
  logic [31:0] next_prdata;
  logic        wr;
  logic        mapped;
  logic        enter_cmd;
  logic [15:0] ext_clr;
  logic [15:0] ext_rise;

  access_if acc ();

  access_check u_check (
    .clk (CORE_CLK),
    .rst (RST),
    .a   (acc)
  );

  function automatic logic [31:0] pkg_addr(input logic [31:0] b,
                                           input logic [3:0]  i);
    return b | {22'h00_0000, i, 6'h00};
  endfunction

  function automatic logic [63:0] save_word(input logic [3:0] i);
    logic [63:0] w;
    // Words not built here, word C included, come from the CPU
    w = CPU_WORD;
    case (i)
      W_PC:    w = {16'h0000, RESUME_PC};
      W_FLAGS:
      begin
        w[FLAGS_HI:FLAGS_LO] = CPU_FLAGS;
        w[FLAG_UNUSED] = 1'b0;
        w[MODES_HI:MODES_LO] = CPU_MODES;
      end
      W_FAULT: if (fault_hold) w = fault_word;
      default: w = CPU_WORD;
    endcase
    return w;
  endfunction

  // Line inputs are asynchronous pins
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      ext_s1 <= EXT_RESET;
      ext_s2 <= EXT_RESET;
      ext_q  <= EXT_RESET;
    end
    else
    begin
      ext_s1 <= EXT_LINE;
      ext_s2 <= ext_s1;
      ext_q  <= ext_s2;
    end
  end

  assign ext_rise = ext_s2 & ~ext_q;
  assign wr = PSEL && PENABLE && PWRITE;
  assign mapped = (PADDR == REG_CTRL) || (PADDR == REG_BASE) ||
                  (PADDR == REG_EXT) || (PADDR == REG_STATUS) ||
                  (PADDR == REG_FAULT);
  assign enter_cmd = wr && PADDR == REG_CTRL && PWDATA[CTRL_ENTER] &&
                     state == ST_MON;
  assign ext_clr = (wr && PADDR == REG_EXT) ? PWDATA[15:0] : 16'h0000;

  // Bus registers, external flags and idle
  always_comb
  begin
    next_base = base;
    next_idle = idle;
    next_wake = 1'b0;
    next_prdata = prdata;
    if (wr && PADDR == REG_BASE)
      next_base = {PWDATA[31:ALIGN_BITS], 10'h000};
    // Set beats clear; unused lines never latch
    next_ext_flag = (ext_flag & ~ext_clr) |
                    (ext_rise & EXT_LINES);
    if (wr && PADDR == REG_CTRL && PWDATA[CTRL_IDLE] && state == ST_MON)
      next_idle = 1'b1;
    // Pending flags are recognised in monitor only while idling
    if (idle && |ext_flag)
    begin
      next_wake = 1'b1;
      next_idle = 1'b0;
    end
    if (enter_cmd)
      next_idle = 1'b0;
    if (PSEL && !PENABLE)
    begin
      unique case (PADDR)
        REG_BASE:   next_prdata = base;
        REG_EXT:    next_prdata = {16'h0000, ext_flag};
        REG_STATUS: next_prdata = {24'h00_0000, fault_hold, idle, vec,
                                   state};
        REG_FAULT:  next_prdata = fault_word[63:32];
        default:    next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      base     <= BASE_RESET;
      ext_flag <= EXT_RESET;
      idle     <= 1'b0;
      wake     <= 1'b0;
      prdata   <= 32'h0000_0000;
    end
    else
    begin
      base     <= next_base;
      ext_flag <= next_ext_flag;
      idle     <= next_idle;
      wake     <= next_wake;
      prdata   <= next_prdata;
    end
  end

  // Checks run only on job-mode references
  always_comb
  begin
    acc.valid = (state == ST_JOB) && REF_VALID;
    acc.kind  = REF_KIND;
    acc.hit   = REF_HIT;
    acc.perm  = key_word[{~REF_KEY, 4'hF} -: 4];
  end

  // Exchange sequencer
  always_comb
  begin
    next_state = state;
    next_idx = idx;
    next_job_base = job_base;
    next_fault_word = fault_word;
    next_fault_hold = fault_hold;
    next_key_word = key_word;
    next_vec = vec;
    next_mem_req = mem_req;
    next_mem_we = mem_we;
    next_mem_addr = mem_addr;
    next_mem_wdata = mem_wdata;
    next_load_valid = 1'b0;
    next_load_idx = load_idx;
    next_load_data = load_data;
    next_mon_start = 1'b0;
    next_mon_pc = mon_pc;
    unique case (state)
      ST_MON:
      begin
        if (enter_cmd)
        begin
          next_state = ST_LOAD;
          next_idx = 4'h0;
          next_job_base = base;
          next_mem_req = 1'b1;
          next_mem_we = 1'b0;
          next_mem_addr = pkg_addr(base, 4'h0);
        end
      end
      ST_LOAD:
      begin
        if (MEM_ACK)
        begin
          next_load_valid = 1'b1;
          next_load_idx = idx;
          next_load_data = MEM_RDATA;
          if (idx == W_KEYS)
            next_key_word = MEM_RDATA;
          if (idx == PKG_LAST)
          begin
            next_state = ST_JOB;
            next_mem_req = 1'b0;
          end
          else
          begin
            next_idx = idx + 4'h1;
            next_mem_addr = pkg_addr(job_base, idx + 4'h1);
          end
        end
      end
      ST_JOB:
      begin
        // Fault first: the faulting reference must not complete
        if (acc.fault)
        begin
          next_fault_word = {12'h000, acc.cause, REF_VADDR};
          next_fault_hold = 1'b1;
          next_vec = VEC_ACCESS;
        end
        else if (ILLEGAL_OP)
          next_vec = VEC_ILLEGAL;
        else if (EXIT_FORCE)
          next_vec = VEC_EXIT;
        else if (|ext_flag)
          next_vec = VEC_EXT;
        if (acc.fault || ILLEGAL_OP || EXIT_FORCE || |ext_flag)
        begin
          next_state = ST_GET;
          next_idx = 4'h0;
        end
      end
      ST_GET:
      begin
        next_mem_wdata = save_word(idx);
        next_mem_req = 1'b1;
        next_mem_we = 1'b1;
        next_mem_addr = pkg_addr(job_base, idx);
        next_state = ST_PUT;
      end
      ST_PUT:
      begin
        if (MEM_ACK)
        begin
          next_mem_req = 1'b0;
          next_mem_we = 1'b0;
          if (idx == PKG_LAST)
          begin
            next_state = ST_MON;
            next_fault_hold = 1'b0;
            next_mon_start = 1'b1;
            next_mon_pc = MON_REG_DATA[47:0];
          end
          else
          begin
            next_idx = idx + 4'h1;
            next_state = ST_GET;
          end
        end
      end
      default: next_state = ST_MON;
    endcase
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      state      <= ST_MON;
      idx        <= 4'h0;
      job_base   <= BASE_RESET;
      fault_word <= 64'h0000_0000_0000_0000;
      fault_hold <= 1'b0;
      key_word   <= 64'h0000_0000_0000_0000;
      vec        <= VEC_EXIT;
      mem_req    <= 1'b0;
      mem_we     <= 1'b0;
      mem_addr   <= BASE_RESET;
      mem_wdata  <= 64'h0000_0000_0000_0000;
      load_valid <= 1'b0;
      load_idx   <= 4'h0;
      load_data  <= 64'h0000_0000_0000_0000;
      mon_start  <= 1'b0;
      mon_pc     <= 48'h0000_0000_0000;
    end
    else
    begin
      state      <= next_state;
      idx        <= next_idx;
      job_base   <= next_job_base;
      fault_word <= next_fault_word;
      fault_hold <= next_fault_hold;
      key_word   <= next_key_word;
      vec        <= next_vec;
      mem_req    <= next_mem_req;
      mem_we     <= next_mem_we;
      mem_addr   <= next_mem_addr;
      mem_wdata  <= next_mem_wdata;
      load_valid <= next_load_valid;
      load_idx   <= next_load_idx;
      load_data  <= next_load_data;
      mon_start  <= next_mon_start;
      mon_pc     <= next_mon_pc;
    end
  end

  assign PRDATA = prdata;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped;
  assign SAVE_IDX = idx;
  assign LOAD_VALID = load_valid;
  assign LOAD_IDX = load_idx;
  assign LOAD_DATA = load_data;
  assign JOB_MODE = (state == ST_JOB);
  assign MON_REG_SEL = vec;
  assign MON_START = mon_start;
  assign MON_PC = mon_pc;
  assign IDLE_WAKE = wake;
  assign MEM_REQ = mem_req;
  assign MEM_WE = mem_we;
  assign MEM_ADDR = mem_addr;
  assign MEM_WDATA = mem_wdata;

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);

  a_fault_leaves_job: assert property (
    (state == ST_JOB && acc.fault) |=> (state == ST_GET && fault_hold))
    else $error("access fault did not start the exchange");

  a_wake_only_idle: assert property (
    (state == ST_MON && !idle) |=> !wake)
    else $error("interrupt recognised outside idle");

  a_flags_held: assert property (
    !(wr && PADDR == REG_EXT)
      |=> ((ext_flag & $past(ext_flag)) == $past(ext_flag)))
    else $error("external flag lost without a clear");

  a_unused_lines: assert property (
    (ext_flag & ~EXT_LINES) == 16'h0000)
    else $error("unassigned external line latched");

  a_pkg_aligned: assert property (
    mem_req |-> (mem_addr[9:0] & 10'h03F) == 10'h000)
    else $error("package address not aligned");

  a_save_same_base: assert property (
    (mem_req && mem_we) |-> mem_addr[31:ALIGN_BITS] ==
                            job_base[31:ALIGN_BITS])
    else $error("package saved away from its load address");

  a_full_load: assert property (
    (state == ST_LOAD && MEM_ACK && idx == PKG_LAST)
      |=> (state == ST_JOB && load_valid && load_idx == PKG_LAST))
    else $error("job entered before the whole package loaded");

  a_access_vector: assert property (
    (state == ST_PUT && MEM_ACK && idx == PKG_LAST && fault_hold)
      |=> (mon_start && MON_REG_SEL == 3'h7))
    else $error("access fault entry used wrong register");

  a_save_then_mon: assert property (
    (state == ST_PUT && MEM_ACK && idx == PKG_LAST)
      |=> (state == ST_MON && mon_start && !mem_req))
    else $error("monitor entered without completing the save");

endmodule
`default_nettype wire

/* File: verilog/xchg_pkg.sv */
// Constants and types shared by the job/monitor exchange block
`default_nettype none
package xchg_pkg;
  // Register byte offsets on the bus
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_BASE   = 8'h04;
  localparam logic [7:0] REG_EXT    = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_FAULT  = 8'h10;
  localparam int CTRL_ENTER = 0;
  localparam int CTRL_IDLE  = 1;
  localparam logic [31:0] BASE_RESET = 32'h0000_0000;
  localparam logic [15:0] EXT_RESET  = 16'h0000;
  // Lines 1..12 are channels, 15 is the interval timer
  localparam logic [15:0] EXT_LINES  = 16'h9FFE;
  localparam int TIMER_LINE = 15;
  // Package layout
  localparam logic [3:0] PKG_LAST = 4'hF;
  localparam logic [3:0] W_PC     = 4'h0;
  localparam logic [3:0] W_KEYS   = 4'h2;
  localparam logic [3:0] W_FLAGS  = 4'h3;
  localparam logic [3:0] W_STRING = 4'hC;
  localparam logic [3:0] W_FAULT  = 4'hE;
  localparam int ALIGN_BITS = 10;
  localparam int WORD_SHIFT = 6;
  // Word bit b (numbered from the left) sits at vector index 63-b
  localparam int FLAGS_HI    = 47;
  localparam int FLAGS_LO    = 36;
  localparam int FLAG_UNUSED = 42;
  localparam int MODES_HI    = 50;
  localparam int MODES_LO    = 48;
  // Cause nibble and permission nibble, leftmost bit first
  localparam int C_NOMATCH = 3;
  localparam int C_WRITE   = 2;
  localparam int C_READ    = 1;
  localparam int C_FETCH   = 0;
  localparam int P_WRITE   = 2;
  localparam int P_READ    = 1;
  localparam int P_FETCH   = 0;
  // Monitor register holding the entry address, by cause
  localparam logic [2:0] VEC_ILLEGAL = 3'h3;
  localparam logic [2:0] VEC_EXIT    = 3'h5;
  localparam logic [2:0] VEC_EXT     = 3'h6;
  localparam logic [2:0] VEC_ACCESS  = 3'h7;
  typedef enum logic [2:0] {
    ST_MON  = 3'b000,
    ST_LOAD = 3'b001,
    ST_JOB  = 3'b010,
    ST_GET  = 3'b011,
    ST_PUT  = 3'b100
  } xstate_t;
  typedef enum logic [1:0] {
    REF_READ  = 2'b00,
    REF_WRITE = 2'b01,
    REF_FETCH = 2'b10
  } ref_t;
endpackage
`default_nettype wire

/* File: verilog/access_if.sv */
// Storage reference check request and verdict
`default_nettype none
interface access_if
  import xchg_pkg::*;
  ;
  logic       valid;
  ref_t       kind;
  logic       hit;
  logic [3:0] perm;
  logic       fault;
  logic [3:0] cause;
  modport chk  (input valid, kind, hit, perm, output fault, cause);
  modport user (output valid, kind, hit, perm, input fault, cause);
endinterface
`default_nettype wire

/* File: verilog/access_check.sv */
// Storage access fault detection and cause encoding
`default_nettype none
module access_check
  import xchg_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  access_if.chk     a
);

  always_comb
  begin
    a.cause = 4'h0;
    if (a.valid)
    begin
      if (!a.hit)
      begin
        a.cause[C_NOMATCH] = 1'b1;
        // A write to a missing page is the only double cause
        a.cause[C_WRITE] = (a.kind == REF_WRITE);
      end
      else
      begin
        unique case (a.kind)
          REF_WRITE: a.cause[C_WRITE] = a.perm[P_WRITE];
          REF_READ:  a.cause[C_READ]  = a.perm[P_READ];
          REF_FETCH: a.cause[C_FETCH] = a.perm[P_FETCH];
          default:   a.cause = 4'h0;
        endcase
      end
    end
    a.fault = |a.cause;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_single_cause: assert property (
    a.fault |-> ($onehot(a.cause) || a.cause == 4'hC))
    else $error("access fault with illegal cause pattern");

  a_lockout_fault: assert property (
    (a.valid && a.hit && a.kind == REF_READ && a.perm[P_READ])
      |-> (a.fault && a.cause[C_READ]))
    else $error("read lockout did not raise a fault");

  a_miss_fault: assert property (
    (a.valid && !a.hit) |-> (a.fault && a.cause[C_NOMATCH]))
    else $error("missing translation did not raise a fault");

endmodule
`default_nettype wire

/* File: testbench/far_side.sv */
// Storage, I/O channels and interval timer facing the exchange block
`default_nettype none
module far_side (
  input  wire logic        clk,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [63:0] mem_wdata,
  output logic      [63:0] mem_rdata,
  output logic             mem_ack,
  output logic      [15:0] ext_line,
  input  wire logic        tmr_load,
  input  wire logic [7:0]  tmr_value
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [63:0] mem [4096];
  logic [63:0] rd    = '0;
  logic [14:0] chan  = '0;
  logic [7:0]  tmr   = '0;
  logic        tline = 1'b0;
  logic        ack   = 1'b0;
  int          gap   = 0;
  assign ext_line  = {tline, chan};
  assign mem_ack   = ack;
  // Released bus shows the inverse so a stale word is never taken as good
  assign mem_rdata = ack ? rd : ~rd;
  // Random latency of 0..3 cycles per word exercises slow answers
  always @(posedge clk)
  begin
    ack <= mem_req && !ack && gap == 0;
    if (mem_req && !ack)
    begin
      if (gap == 0)
      begin
        gap     <= $urandom_range(3);
        if (mem_we)
          mem[mem_addr[17:6]] <= mem_wdata;
        else
          rd <= mem[mem_addr[17:6]];
      end
      else
        gap <= gap - 1;
    end
  end
  // Line stays high after expiry until the next load
  always @(posedge clk)
  begin
    if (tmr_load)
      tmr <= tmr_value;
    else if (tmr != 8'h00)
      tmr <= tmr - 8'h01;
    tline <= !tmr_load && (tmr == 8'h01 || tline);
  end
  task automatic raise_line(input int n);
    @(posedge clk);
    mem[12'h0F0 + n] <= 64'(n);
    @(posedge clk);
    chan[n] <= 1'b1;
    repeat (4) @(posedge clk);
    chan[n] <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
// Self-checking bench for the job/monitor exchange block
`default_nettype none
`define CHK(g, e) \
  begin \
    tests_run++; \
    if ((g) !== (e)) \
    begin \
      fail_count++; \
      $display("wrong value at %0t: %h vs %h", $time, g, e); \
    end \
  end
module tb_top
  import xchg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [44:0] MON_HI = 45'h0123_4567_89AB;
  logic        clk = 1'b0, rst = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic        pready, pslverr, job_mode, mon_start, idle_wake;
  logic        ref_valid = 1'b0, ref_hit = 1'b0, load_valid;
  logic [3:0]  load_idx, save_idx;
  logic [63:0] load_data;
  ref_t        ref_kind = REF_READ;
  logic [1:0]  ref_key = '0, k;
  logic [47:0] ref_vaddr = '0, resume_pc = '0, va, mon_pc;
  logic        exit_force = 1'b0, illegal_op = 1'b0, tmr_load = 1'b0;
  logic [11:0] cpu_flags = '0;
  logic [2:0]  cpu_modes = '0, mon_reg_sel;
  logic [63:0] cpu_word = '0, mon_reg_data, mem_wdata, mem_rdata, exp_n;
  logic        mem_req, mem_we, mem_ack;
  logic [31:0] mem_addr;
  logic [15:0] ext_line;
  logic [7:0]  tmr_value = '0;
  logic [63:0] notes [$];
  int          fail_count = 0, tests_run = 0, loads = 0;
  int          exits = 0, cycles = 0, ex = 0;
  ref_t        kinds [7] = '{REF_READ, REF_WRITE, REF_WRITE, REF_READ,
                             REF_FETCH, REF_READ, REF_READ};
  logic [6:0]  hits = 7'b1111100;
  logic [3:0]  perms [7] = '{4'h2, 4'h0, 4'h5, 4'h6, 4'h7, 4'h0, 4'h0};
  logic [3:0]  causes [5] = '{4'h8, 4'hC, 4'h4, 4'h2, 4'h1};
  logic [2:0]  vecs [7] = '{VEC_ACCESS, VEC_ACCESS, VEC_ACCESS, VEC_ACCESS,
                            VEC_ACCESS, VEC_EXIT, VEC_ILLEGAL};
  assign mon_reg_data = {16'hFFFF, MON_HI, mon_reg_sel};
  always #10 clk = ~clk;
  mode_exchange i_dut (
    .CORE_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .EXT_LINE(ext_line),
    .REF_VALID(ref_valid), .REF_KIND(ref_kind), .REF_HIT(ref_hit),
    .REF_KEY(ref_key), .REF_VADDR(ref_vaddr), .EXIT_FORCE(exit_force),
    .ILLEGAL_OP(illegal_op), .RESUME_PC(resume_pc), .CPU_FLAGS(cpu_flags),
    .CPU_MODES(cpu_modes), .CPU_WORD(cpu_word), .SAVE_IDX(save_idx),
    .LOAD_VALID(load_valid), .LOAD_IDX(load_idx), .LOAD_DATA(load_data),
    .JOB_MODE(job_mode), .MON_REG_SEL(mon_reg_sel),
    .MON_REG_DATA(mon_reg_data), .MON_START(mon_start), .MON_PC(mon_pc),
    .IDLE_WAKE(idle_wake), .MEM_REQ(mem_req), .MEM_WE(mem_we),
    .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata), .MEM_RDATA(mem_rdata),
    .MEM_ACK(mem_ack)
  );
  far_side i_far (
    .clk(clk), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
    .ext_line(ext_line), .tmr_load(tmr_load), .tmr_value(tmr_value)
  );
  task automatic close_out();
    $display("checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  function automatic logic [63:0] oldest();
    return (notes.size() != 0) ? notes.pop_front() : 'x;
  endfunction
  // Results are judged on pre-edge values, as the design sampled them
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (load_valid === 1'b1)
    begin
      loads <= loads + 1;
      `CHK(load_data, i_far.mem[12'h400 + load_idx])
    end
    if (mem_ack === 1'b1 && mem_we === 1'b1)
      `CHK(save_idx, mem_addr[9:6])
    if (psel && penable && pready === 1'b1 && !pwrite)
    begin
      exp_n = oldest();
      `CHK({31'h0, pslverr, prdata}, exp_n)
    end
    if (mon_start === 1'b1)
    begin
      exits <= exits + 1;
      exp_n = oldest();
      `CHK({16'h0000, mon_pc}, exp_n)
    end
    if (cycles == 8000)
    begin
      fail_count++;
      close_out();
    end
  end
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    notes.push_back({31'h0, e});
    apb(1'b0, a, '0);
  endtask
  task automatic enter(input logic [1:0] key, input logic [3:0] p);
    int l0;
    l0 = loads;
    for (int w = 0; w < 16; w++)
      i_far.mem[12'h400 + w] = {$urandom, $urandom};
    i_far.mem[12'h402] = 64'(p) << (60 - 16 * key);
    apb(1'b1, REG_CTRL, 32'h0000_0001);
    repeat (300)
      if (loads < l0 + 16)
        @(posedge clk);
    repeat (2) @(posedge clk);
    `CHK(loads - l0, 16)
  endtask
  task automatic wait_exit();
    ex++;
    repeat (400)
      if (exits < ex)
        @(posedge clk);
    `CHK(exits == ex, 1'b1)
  endtask
  initial
  begin
    void'($urandom(71293));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(REG_BASE, {1'b0, BASE_RESET});
    rd(REG_EXT, {17'h0, EXT_RESET});
    rd(8'h20, 33'h1_0000_0000);
    apb(1'b1, REG_BASE, 32'h0001_0155);
    rd(REG_BASE, 33'h0_0001_0000);
    $display("test registers done");
    foreach (hits[i])
      i_far.raise_line(i == 3 ? 3 : (i == 0 ? 0 : 12 + i % 3));
    repeat (8) @(posedge clk);
    rd(REG_EXT, 33'h0_0000_1008);
    apb(1'b1, REG_CTRL, 32'h0000_0002);
    repeat (8)
      if (idle_wake !== 1'b1)
        @(posedge clk);
    `CHK(idle_wake, 1'b1)
    notes.push_back({16'h0000, MON_HI, VEC_EXT});
    enter(2'h0, 4'h0);
    wait_exit();
    apb(1'b1, REG_EXT, 32'h0000_FFFF);
    rd(REG_EXT, 33'h0);
    $display("test external lines done");
    tmr_value <= 8'h14;
    tmr_load  <= 1'b1;
    @(posedge clk);
    tmr_load  <= 1'b0;
    repeat (30) @(posedge clk);
    rd(REG_EXT, 33'h0_0000_8000);
    apb(1'b1, REG_EXT, 32'h0000_8000);
    notes.push_back({16'h0000, MON_HI, VEC_EXT});
    enter(2'h1, 4'h0);
    i_far.raise_line(7);
    wait_exit();
    apb(1'b1, REG_EXT, 32'h0000_0080);
    $display("test timer and channel done");
    for (int i = 0; i < 7; i++)
    begin
      k  = 2'($urandom);
      va = 48'({$urandom, $urandom});
      @(posedge clk);
      resume_pc <= 48'({$urandom, $urandom});
      cpu_flags <= 12'($urandom);
      cpu_modes <= 3'($urandom);
      cpu_word  <= {$urandom, $urandom};
      enter(k, perms[i]);
      `CHK(job_mode, 1'b1)
      notes.push_back({16'h0000, MON_HI, vecs[i]});
      ref_valid  <= 1'b1;
      ref_kind   <= kinds[i];
      ref_hit    <= hits[i];
      ref_key    <= k;
      ref_vaddr  <= va;
      exit_force <= (i == 5);
      illegal_op <= (i == 6);
      @(posedge clk);
      ref_valid  <= 1'b0;
      exit_force <= 1'b0;
      illegal_op <= 1'b0;
      wait_exit();
      `CHK(i_far.mem[12'h400], {16'h0000, resume_pc})
      `CHK(i_far.mem[12'h403][47:36], cpu_flags & 12'hFBF)
      `CHK(i_far.mem[12'h403][50:48], cpu_modes)
      `CHK(i_far.mem[12'h40C], cpu_word)
      if (i < 5)
        `CHK(i_far.mem[12'h40E], {12'h000, causes[i], va})
      if (i < 5)
      begin
        rd(REG_FAULT, {13'h0000, causes[i], va[47:32]});
        rd(REG_STATUS, {27'h000_0000, VEC_ACCESS, 3'h0});
      end
    end
    $display("test exchanges done");
    close_out();
  end
endmodule
`default_nettype wire
